// file: core/tmr_decoder.sv
// tmr_decoder: read-side mark track decoder and word assembler for a
// small block-formatted bidirectional tape, with a classic wishbone slave
// assumes: head pins are asynchronous and pass two flops; one 200 MHz clock
//
// Behaviour
// R1 - in read mode first data flag follows the reverse check sum word
// R2 - each later data flag means one new read word waits in the buffer
// R3 - check sum mark raises block end flag with check sum in buffer
// R4 - exactly one data flag per data word of the block
// R5 - no hardware validity check; check sum word passed like any word
// R6 - only exact mark patterns are accepted, so one bit error never decodes
// R7 - once synced, mark early or missing at six shifts raises error flag
// R8 - mode may change at any moment while tape moves
// R9 - program allows two word times recovery and recounts words after writes
// R10 - one decode table serves both directions via complement obverse marks
// R11 - assembly buffer shifts opposite ways for forward and reverse motion
// R12 - reverse reading gives words last first with bit content unchanged
// R13 - only the end mark ahead of the motion is recognised
// R14 - coasting or turning in an end zone is no error
// R15 - end mark recognised again after every three bit shift
// R16 - in normal modes the end mark stops tape and raises error
// R17 - in timing and mark write mode no marks are detected
// R18 - marks decoded only from the selected transport
// R19 - behaviour independent of block length
// R20 - repeated 01 gap codes give neither detections nor errors
// R21 - eight bit window; mark taken only if previous mark tail matches
// R22 - with break enabled any flag requests a program break
// R23 - data and block end flags hold until unload or clear
`timescale 1ns/100ps

`include "tmr_defines.svh"

module tmr_decoder
  import tmr_pkg::*;
#(
  parameter int UNITS = 2  // transports on the shared head bus
) (
  input  wire logic                   clk_i,     // 200 MHz clock
  input  wire logic                   rst_i,     // synchronous reset, high
  // classic wishbone slave
  input  wire logic                   cyc_i,     // bus cycle
  input  wire logic                   stb_i,     // strobe
  input  wire logic                   we_i,      // write enable
  input  wire logic [3:0]             adr_i,     // byte address
  input  wire logic [3:0]             sel_i,     // byte lanes
  input  wire logic [31:0]            dat_i,     // write data
  output logic      [31:0]            dat_o,     // read data
  output logic                        ack_o,     // cycle acknowledge
  // transports
  input  wire tmr_head_s [UNITS-1:0]  heads_i,   // head signals per unit
  output logic                        run_o,     // tape motion request
  output logic                        rev_o,     // reverse motion
  output logic      [2:0]             unit_o,    // selected transport
  output logic                        brk_o      // program break request
);

  // elaboration check: unit field is three bits wide
  if (UNITS < 1 || UNITS > 8) begin : g_bad_units
    $error("tmr_decoder: UNITS must lie in 1..8");
  end

  // control register contents
  logic [2:0]  mode_bits;
  logic        rev;
  logic        run;
  logic        brk_en;
  logic [2:0]  unit;
  tmr_mode_e   mode;

  // flags
  logic        data_flag;
  logic        bend_flag;
  logic        err_flag;

  // decoder state
  logic [`TMR_WIN_W-1:0]   window;
  logic [1:0]              prev_tail;
  logic                    synced;
  logic [2:0]              shift_cnt;
  logic                    in_end_zone;
  logic [`TMR_WORD_W-1:0]  asm_buf;
  logic [`TMR_WORD_W-1:0]  out_word;

  // synchroniser stages for the selected head
  tmr_head_s   head_sel;
  tmr_head_s   sync1;
  tmr_head_s   sync2;
  logic        timing_d;
  logic        strobe;

  // bus decode
  logic        bus_req;
  logic        wr_ctrl;
  logic        wr_status;
  logic        rd_data;
  logic [31:0] next_dat;

  // decode results
  tmr_hit_s    hit;
  logic        legit;
  logic        end_seen;
  logic [2:0]  next_cnt;
  logic        seq_err;
  logic [`TMR_WIN_W-1:0]  next_window;
  logic [`TMR_WORD_W-1:0] next_buf;
  logic        normal_mode;
  logic        detect_en;
  logic        read_mode;

  // exact pattern compare against the single table
  function automatic logic is_mark(input logic [`TMR_MARK_W-1:0] w,
                                   input logic [`TMR_MARK_W-1:0] code);
    is_mark = (w == code);  // see R6, see R10
  endfunction : is_mark

  assign mode   = tmr_mode_e'(mode_bits);
  assign run_o  = run;
  assign rev_o  = rev;
  assign unit_o = unit;

  // mode classes; an unknown code counts as abnormal and decodes nothing
  always_comb begin
    normal_mode = 1'b0;
    read_mode   = 1'b0;
    unique case (mode)
      TMR_MODE_MOVE:   normal_mode = 1'b1;
      TMR_MODE_SEARCH: normal_mode = 1'b1;
      TMR_MODE_READ: begin
        normal_mode = 1'b1;
        read_mode   = 1'b1;
      end
      TMR_MODE_WRITE:  normal_mode = 1'b1;
      TMR_MODE_WTM:    normal_mode = 1'b0;  // see R17
      default:         normal_mode = 1'b0;
    endcase
  end

  // marks are being written in timing-track mode, so nothing decodes
  assign detect_en = normal_mode;  // see R17

  // pick only the selected transport; others get no protection
  always_comb begin
    head_sel = '0;
    for (int i = 0; i < UNITS; i++) begin
      if (unit == 3'(i)) begin
        head_sel = heads_i[i];  // see R18
      end
    end
  end

  // two flops before any logic, then a third for the strobe edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1    <= '0;
      sync2    <= '0;
      timing_d <= 1'b0;
    end else begin
      sync1    <= head_sel;
      sync2    <= sync1;
      timing_d <= sync2.timing;
    end
  end

  // timing strobe acts as the bit clock enable
  assign strobe = sync2.timing & ~timing_d;

  // window shifts one mark bit per strobe; reverse reading sees the
  // same bits because of the complement obverse layout
  assign next_window = {window[`TMR_WIN_W-2:0], sync2.mark};  // see R21

  // decode on the updated window
  always_comb begin
    hit.fwd_blk  = is_mark(next_window[5:0], `TMR_MARK_FWD_BLK);
    hit.rev_blk  = is_mark(next_window[5:0], `TMR_MARK_REV_BLK);
    hit.rev_csum = is_mark(next_window[5:0], `TMR_MARK_REV_CSUM);
    hit.csum     = is_mark(next_window[5:0], `TMR_MARK_CSUM);
    hit.data     = is_mark(next_window[5:0], `TMR_MARK_DATA);
    hit.end_mark = is_mark(next_window[5:0], `TMR_MARK_END);
  end

  // a control mark counts only if the two window bits above it match the tail
  // of the previous mark; the gap tail 01 admits the first block mark
  assign legit = detect_en
               & (next_window[7:6] == prev_tail)  // see R21
               & (hit.fwd_blk | hit.rev_blk | hit.rev_csum
                  | hit.csum | hit.data);

  // end mark repeats every three bits, so no tail check is possible
  assign end_seen = detect_en & hit.end_mark;  // see R15, see R13

  // spacing check: a mark must land on exactly the sixth shift
  assign next_cnt = shift_cnt + 3'h1;
  assign seq_err  = synced & ((legit & (next_cnt != `TMR_MARK_SHIFTS))
                  | (~legit & (next_cnt == `TMR_MARK_SHIFTS)));  // see R7

  // window and tail tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window    <= '0;
      prev_tail <= `TMR_GAP_TAIL;
    end else if (strobe) begin
      window <= next_window;
      if (legit & hit.rev_blk) begin
        prev_tail <= `TMR_GAP_TAIL;  // see R20
      end else if (legit) begin
        prev_tail <= next_window[1:0];
      end
    end
  end

  // synchronisation: gained at the forward block mark, dropped after
  // the closing block mark so the 0101 gap may run on without error
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      synced    <= 1'b0;
      shift_cnt <= 3'h0;
    end else if (!detect_en) begin
      synced    <= 1'b0;
      shift_cnt <= 3'h0;
    end else if (strobe) begin
      if (legit & hit.rev_blk) begin
        synced    <= 1'b0;  // see R20
        shift_cnt <= 3'h0;
      end else if (legit & hit.fwd_blk) begin
        synced    <= 1'b1;
        shift_cnt <= 3'h0;
      end else if (legit | (next_cnt == `TMR_MARK_SHIFTS)) begin
        shift_cnt <= 3'h0;
      end else begin
        shift_cnt <= next_cnt;
      end
    end
  end

  // word assembly: forward shifts left, reverse shifts right with the
  // inverted flux polarity undone, so words keep their written bits
  assign next_buf = rev
                  ? {~sync2.data, asm_buf[`TMR_WORD_W-1:`TMR_SLOT_W]}  // see R11
                  : {asm_buf[`TMR_WORD_W-`TMR_SLOT_W-1:0], sync2.data};

  // the buffer runs in every mode; no parity or sum is checked here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      asm_buf <= '0;
    end else if (strobe) begin
      asm_buf <= next_buf;  // see R5, see R12
    end
  end

  // word handed to the program when its mark completes; no word count
  // is kept, so any block length works
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_word <= '0;
    end else if (strobe & legit & read_mode
                 & (hit.rev_csum | hit.data | hit.csum)) begin
      out_word <= next_buf;  // see R19, see R12
    end
  end

  // end zone: reloaded at each strobe, high only while the end mark is seen, shown in status only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_end_zone <= 1'b0;
    end else if (strobe) begin
      in_end_zone <= end_seen;
    end
  end

  // bus request; ack rises one cycle after the strobe and drops after
  assign bus_req   = cyc_i & stb_i & ~ack_o;
  assign wr_ctrl   = bus_req & we_i & (adr_i == `TMR_ADDR_CTRL);
  assign wr_status = bus_req & we_i & (adr_i == `TMR_ADDR_STATUS) & sel_i[0];
  assign rd_data   = bus_req & ~we_i & (adr_i == `TMR_ADDR_DATA);

  // control register; writes land at any time, even mid motion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_bits <= 3'(`TMR_CTRL_RESET);
      rev       <= 1'b0;
      run       <= 1'b0;
      brk_en    <= 1'b0;
      unit      <= 3'h0;
    end else begin
      if (wr_ctrl & sel_i[0]) begin
        mode_bits <= dat_i[`TMR_CTRL_MODE_MSB:`TMR_CTRL_MODE_LSB];  // see R8
        rev       <= dat_i[`TMR_CTRL_REV];
        run       <= dat_i[`TMR_CTRL_RUN];
        brk_en    <= dat_i[`TMR_CTRL_BRK_EN];
      end
      if (wr_ctrl & sel_i[0]) begin
        unit[1:0] <= dat_i[`TMR_CTRL_UNIT_LSB+1:`TMR_CTRL_UNIT_LSB];
      end
      if (wr_ctrl & sel_i[1]) begin
        unit[2] <= dat_i[`TMR_CTRL_UNIT_MSB];
      end
      // the end mark stops the tape; a stopped tape coasting on is
      // not stopped again and raises nothing
      if (strobe & end_seen & run) begin
        run <= 1'b0;  // see R16, see R14
      end
    end
  end

  // data flag: set by the reverse check sum word and every data word;
  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_flag <= 1'b0;
    end else if (strobe & legit & read_mode & (hit.rev_csum | hit.data)) begin
      data_flag <= 1'b1;  // see R1, see R2, see R4
    end else if (rd_data | (wr_status & dat_i[`TMR_ST_DATA])) begin
      data_flag <= 1'b0;  // see R23
    end
  end

  // block end flag: check sum word now sits in the buffer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bend_flag <= 1'b0;
    end else if (strobe & legit & read_mode & hit.csum) begin
      bend_flag <= 1'b1;  // see R3
    end else if (rd_data | (wr_status & dat_i[`TMR_ST_BEND])) begin
      bend_flag <= 1'b0;  // see R23
    end
  end

  // error flag: mark spacing fault, or running on into the end zone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_flag <= 1'b0;
    end else if (strobe & (seq_err | (end_seen & run))) begin
      err_flag <= 1'b1;  // see R7, see R16, see R14
    end else if (wr_status & dat_i[`TMR_ST_ERR]) begin
      err_flag <= 1'b0;
    end
  end

  // any raised flag asks for a break when enabled
  assign brk_o = brk_en & (data_flag | bend_flag | err_flag);  // see R22

  // read mux; unmapped addresses read zero and are still acknowledged
  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      `TMR_ADDR_CTRL: begin
        next_dat[`TMR_CTRL_MODE_MSB:`TMR_CTRL_MODE_LSB] = mode_bits;
        next_dat[`TMR_CTRL_REV]    = rev;
        next_dat[`TMR_CTRL_RUN]    = run;
        next_dat[`TMR_CTRL_BRK_EN] = brk_en;
        next_dat[`TMR_CTRL_UNIT_MSB:`TMR_CTRL_UNIT_LSB] = unit;
      end
      `TMR_ADDR_STATUS: begin
        next_dat[`TMR_ST_DATA]    = data_flag;
        next_dat[`TMR_ST_BEND]    = bend_flag;
        next_dat[`TMR_ST_ERR]     = err_flag;
        next_dat[`TMR_ST_SYNC]    = synced;
        next_dat[`TMR_ST_ENDZONE] = in_end_zone;
      end
      `TMR_ADDR_DATA: begin
        next_dat[`TMR_WORD_W-1:0] = out_word;
      end
      default: next_dat = 32'h0000_0000;
    endcase
  end

  // registered answer, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? next_dat : 32'h0000_0000;
    end
  end

endmodule : tmr_decoder

// file: core/tmr_defines.svh
// tmr_defines.svh: offsets, field positions, reset values and mark codes
// assumes: included by bare name wherever the tape mark reader needs a number
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// register byte addresses on the wishbone slave
`define TMR_ADDR_CTRL     4'h0
`define TMR_ADDR_STATUS   4'h4
`define TMR_ADDR_DATA     4'h8

// control register fields
`define TMR_CTRL_MODE_LSB 0
`define TMR_CTRL_MODE_MSB 2
`define TMR_CTRL_REV      3
`define TMR_CTRL_RUN      4
`define TMR_CTRL_BRK_EN   5
`define TMR_CTRL_UNIT_LSB 6
`define TMR_CTRL_UNIT_MSB 8
`define TMR_CTRL_RESET    32'h0000_0000

// status register fields, bits 2:0 are write-one-to-clear
`define TMR_ST_DATA       0
`define TMR_ST_BEND       1
`define TMR_ST_ERR        2
`define TMR_ST_SYNC       3
`define TMR_ST_ENDZONE    4

// six-bit mark codes; pairs are complement obverses of each other
`define TMR_MARK_FWD_BLK  6'h16
`define TMR_MARK_REV_BLK  6'h25
`define TMR_MARK_REV_CSUM 6'h08
`define TMR_MARK_CSUM     6'h3b
// data mark 000111 maps to itself, and unlike 101010 it cannot turn up
// again two shifts into the next data mark with a matching tail
`define TMR_MARK_DATA     6'h07
`define TMR_MARK_END      6'h12

// window and word geometry
`define TMR_WIN_W         8
`define TMR_MARK_W        6
`define TMR_WORD_W        18
`define TMR_SLOT_W        3
`define TMR_MARK_SHIFTS   3'h6
`define TMR_GAP_TAIL      2'h1

`endif

// file: core/tmr_pkg.sv
// tmr_pkg: types shared by the tape mark reader and its surroundings
// assumes: tmr_defines.svh holds every number except the mode codes below
package tmr_pkg;

  // operating modes written by the program
  typedef enum logic [2:0] {
    TMR_MODE_MOVE   = 3'b000,
    TMR_MODE_SEARCH = 3'b001,
    TMR_MODE_READ   = 3'b010,
    TMR_MODE_WRITE  = 3'b011,
    TMR_MODE_WTM    = 3'b100
  } tmr_mode_e;

  // one transport's head signals, all asynchronous to clk_i
  typedef struct packed {
    logic       timing;
    logic       mark;
    logic [2:0] data;
  } tmr_head_s;

  // decoded mark classes
  typedef struct packed {
    logic fwd_blk;
    logic rev_blk;
    logic rev_csum;
    logic csum;
    logic data;
    logic end_mark;
  } tmr_hit_s;

endpackage : tmr_pkg

// file: verification/tmr_decoder_chk.sv
// tmr_decoder_chk: port-level assertions for the tape mark reader
// assumes: bound into every tmr_decoder, one clock, master uses all lanes
`timescale 1ns/100ps
module tmr_decoder_chk
  import tmr_pkg::*;
#(
  parameter int UNITS = 2  // transports
) (
  input wire logic                  clk_i,   // clock
  input wire logic                  rst_i,   // sync reset
  input wire logic                  cyc_i,   // bus cycle
  input wire logic                  stb_i,   // strobe
  input wire logic                  we_i,    // write
  input wire logic [3:0]            adr_i,   // address
  input wire logic [3:0]            sel_i,   // lanes
  input wire logic [31:0]           dat_i,   // write data
  input wire logic [31:0]           dat_o,   // read data
  input wire logic                  ack_o,   // acknowledge
  input wire tmr_head_s [UNITS-1:0] heads_i, // heads
  input wire logic                  run_o,   // motion
  input wire logic                  rev_o,   // reverse
  input wire logic [2:0]            unit_o,  // unit
  input wire logic                  brk_o    // break
);
  logic [5:0] shadow;
  logic       wr_ctrl;
  // control writes seen on the bus; full-lane only, as the bench uses
  assign wr_ctrl = cyc_i && stb_i && we_i && !ack_o && adr_i == 4'h0 && sel_i == 4'hf;
  // copy of mode, rev, run and break enable
  always_ff @(posedge clk_i) begin
    if (rst_i) shadow <= 6'h00;
    else if (wr_ctrl) shadow <= dat_i[5:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  sequence s_answer; ack_o ##1 !ack_o; endsequence
  AST_ACK_ONCE: assert property (s_take |=> s_answer)
    else $error("ack not one pulse one cycle after request");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero while idle");
  AST_RUN_WR: assert property (wr_ctrl |=> run_o == $past(dat_i[4]))
    else $error("run does not follow control write");
  AST_REV_UNIT: assert property (wr_ctrl |=> rev_o == $past(dat_i[3])
                                 && unit_o == $past(dat_i[8:6]))
    else $error("direction or unit not from control write");
  AST_RUN_ROSE: assert property ($rose(run_o) |-> ack_o)
    else $error("motion started without a bus write");
  AST_UNIT_HOLD: assert property (!ack_o |-> $stable(unit_o))
    else $error("unit changed without a bus write");
  AST_BRK_EN: assert property (brk_o |-> shadow[5])
    else $error("break request while breaks disabled");
  AST_BRK_FELL: assert property ($fell(brk_o) |-> ack_o)
    else $error("break dropped without program action");
  AST_WTM_RUN: assert property (shadow[2:0] == 3'h4 && run_o && !wr_ctrl |=> run_o)
    else $error("motion stopped in track write mode");
  AST_WTM_BRK: assert property (shadow[2:0] == 3'h4 && !ack_o |-> !$rose(brk_o))
    else $error("flag raised in track write mode");
endmodule : tmr_decoder_chk

bind tmr_decoder tmr_decoder_chk #(.UNITS(UNITS)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .heads_i, .run_o, .rev_o, .unit_o, .brk_o);

// file: verification/tmr_decoder_tb_top.sv
// tmr_decoder_tb_top: directed scenarios for the tape mark reader
// assumes: tape model at the heads, bench is the wishbone master
`timescale 1ns/100ps
`include "tmr_defines.svh"
`define CHK(nm, ex, gt) begin \
  total_checks++; \
  if ((gt) !== (ex)) begin \
    n_fail++; \
    $display("mismatch %s exp %h got %h", nm, ex, gt); \
  end \
end
module tmr_decoder_tb_top
  import tmr_pkg::*;
;
  logic            clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, run_o, rev_o, brk_o;
  logic [3:0]      adr_i, sel_i;
  logic [31:0]     dat_i, dat_o, rd;
  logic [2:0]      unit_o;
  tmr_head_s [1:0] heads_i;
  logic [17:0]     wd [3] = '{18'h2a5c1, 18'h00fff, 18'h3f000};
  int              n_fail = 0;
  int              total_checks = 0;

  tmr_decoder #(.UNITS(2)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .heads_i, .run_o, .rev_o, .unit_o, .brk_o);
  tmr_tape_model #(.UNITS(2)) u_tape (.clk_i, .heads_o(heads_i));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'hf;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    rd = dat_o;
    `CHK("ack", 1'b1, ack_o)
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string nm);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask : rdchk

  // n mark bits, msb first; reverse sends inverted slots, low slot first
  task automatic word(input int u, input logic [5:0] mk, input logic [17:0] w,
                      input logic rv, input int n);
    for (int i = 0; i < n; i++)
      u_tape.slot(u, mk[n-1-i], rv ? ~w[3*i+:3] : w[17-3*i-:3]);
  endtask : word

  task automatic gap(input int n);
    for (int i = 0; i < n; i++)
      word(0, 6'h01, 18'h0, 1'b0, 2);
  endtask : gap

  task automatic t_regs();
    `CHK("idle pins", 4'h0, {run_o, rev_o, brk_o, ack_o})
    rdchk(`TMR_ADDR_CTRL, 32'h1ff, `TMR_CTRL_RESET, "ctrl reset");
    wb(1'b1, 4'hc, 32'h1ff);
    rdchk(4'hc, 32'hffffffff, 32'h0, "unmapped");
    wb(1'b1, `TMR_ADDR_CTRL, 32'h1b8);
    `CHK("pins", 5'h1e, {run_o, rev_o, unit_o})
    rdchk(`TMR_ADDR_CTRL, 32'h1ff, 32'h1b8, "ctrl");
  endtask : t_regs

  // forward block: long gap, sync, first word, data words, check sum
  task automatic t_fwd();
    wb(1'b1, `TMR_ADDR_CTRL, 32'h32);
    gap(6); // two word times of gap before the first mark
    rdchk(`TMR_ADDR_STATUS, 32'hf, 32'h0, "gap");
    word(0, `TMR_MARK_FWD_BLK, 18'h0, 1'b0, 6);
    rdchk(`TMR_ADDR_STATUS, 32'hf, 32'h8, "sync");
    for (int k = 0; k < 3; k++) begin
      word(0, k != 0 ? `TMR_MARK_DATA : `TMR_MARK_REV_CSUM, wd[k], 1'b0, 6);
      `CHK("brk", 1'b1, brk_o)
      rdchk(`TMR_ADDR_STATUS, 32'h7, 32'h1, "dflag");
      rdchk(`TMR_ADDR_DATA, 32'h3ffff, {14'h0, wd[k]}, "word");
      `CHK("brk clr", 1'b0, brk_o)
    end
    word(0, `TMR_MARK_CSUM, 18'h2b1c3, 1'b0, 6);
    rdchk(`TMR_ADDR_STATUS, 32'h7, 32'h2, "bend");
    rdchk(`TMR_ADDR_DATA, 32'h3ffff, 32'h2b1c3, "csum");
    word(0, `TMR_MARK_REV_BLK, 18'h0, 1'b0, 6);
    rdchk(`TMR_ADDR_STATUS, 32'hf, 32'h0, "closed");
  endtask : t_fwd

  // a data mark with one bad bit: no flag, spacing error at six
  task automatic t_err();
    gap(2);
    word(0, `TMR_MARK_FWD_BLK, 18'h0, 1'b0, 6);
    word(0, `TMR_MARK_DATA ^ 6'h04, wd[0], 1'b0, 6);
    rdchk(`TMR_ADDR_STATUS, 32'h7, 32'h4, "spacing");
    `CHK("brk err", 1'b1, brk_o)
    wb(1'b1, `TMR_ADDR_STATUS, 32'h7);
    rdchk(`TMR_ADDR_STATUS, 32'h7, 32'h0, "w1c");
  endtask : t_err

  task automatic t_rev();
    wb(1'b1, `TMR_ADDR_CTRL, 32'h3a);
    `CHK("rev", 1'b1, rev_o)
    gap(3);
    word(0, `TMR_MARK_FWD_BLK, 18'h0, 1'b1, 6);
    for (int k = 0; k < 2; k++) begin
      word(0, k != 0 ? `TMR_MARK_DATA : `TMR_MARK_REV_CSUM, wd[k], 1'b1, 6);
      rdchk(`TMR_ADDR_DATA, 32'h3ffff, {14'h0, wd[k]}, "rev word");
    end
  endtask : t_rev

  // end marks: obverse ignored, stop, coast, three-bit repeat
  task automatic t_end();
    wb(1'b1, `TMR_ADDR_CTRL, 32'h12);
    word(0, 6'h2d, 18'h0, 1'b0, 6);
    `CHK("obverse", 1'b1, run_o)
    word(0, `TMR_MARK_END, 18'h0, 1'b0, 6);
    `CHK("stop", 1'b0, run_o)
    rdchk(`TMR_ADDR_STATUS, 32'h4, 32'h4, "end err");
    wb(1'b1, `TMR_ADDR_STATUS, 32'h7);
    word(0, 6'h02, 18'h0, 1'b0, 3);
    rdchk(`TMR_ADDR_STATUS, 32'h4, 32'h0, "coast");
    wb(1'b1, `TMR_ADDR_CTRL, 32'h12);
    word(0, 6'h02, 18'h0, 1'b0, 3);
    `CHK("repeat", 1'b0, run_o)
  endtask : t_end

  // track write mode and a deselected transport ignore end marks
  task automatic t_abn();
    wb(1'b1, `TMR_ADDR_CTRL, 32'h14);
    word(0, `TMR_MARK_END, 18'h0, 1'b0, 6);
    `CHK("wtm", 1'b1, run_o)
    wb(1'b1, `TMR_ADDR_CTRL, 32'h52);
    word(0, `TMR_MARK_END, 18'h0, 1'b0, 6);
    `CHK("desel", 1'b1, run_o)
    word(1, `TMR_MARK_END, 18'h0, 1'b0, 6);
    `CHK("sel", 1'b0, run_o)
  endtask : t_abn

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // watchdog, far beyond the about 1250 clocks expected
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  // main sequence, mid-run resets clear sync between scenarios except t_fwd and t_err
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 4'h0;
    sel_i = 4'hf;
    dat_i = 32'h0;
    do_reset();
    t_regs();
    do_reset();
    t_fwd();
    t_err();
    do_reset();
    t_rev();
    do_reset();
    t_end();
    do_reset();
    t_abn();
    end_of_test();
  end
endmodule : tmr_decoder_tb_top

// file: verification/tmr_tape_model.sv
// tmr_tape_model: behavioural transport heads, one slot per task call
// assumes: the bench calls slot() from one process at a time
`timescale 1ns/100ps
module tmr_tape_model
  import tmr_pkg::*;
#(
  parameter int UNITS = 2  // transports
) (
  input  wire logic             clk_i,   // bench clock
  output tmr_head_s [UNITS-1:0] heads_o  // head pins
);
  // timing stands low between slots, it never runs free
  initial heads_o = '0;
  // data first, strobe high four clocks, then stale lines are inverted
  task automatic slot(input int u, input logic m, input logic [2:0] d);
    @(posedge clk_i);
    heads_o[u].mark <= m;
    heads_o[u].data <= d;
    @(posedge clk_i);
    heads_o[u].timing <= 1'b1;
    repeat (4) @(posedge clk_i);
    heads_o[u].timing <= 1'b0;
    repeat (3) @(posedge clk_i);
    heads_o[u].mark <= ~m;
    heads_o[u].data <= ~d;
  endtask : slot
endmodule : tmr_tape_model
